// file: src/dom_odt_timing.sv
// How it works
// [R1] controller keeps ODT high 4 clocks from rise and after a BC4 write
// [R2] without a write, only ODT rise to ODT fall is measured
// [R3] ODT rising with a BC4 write and held 4 clocks is legal
// [R4] ODT rising with a BL8 write must stay high 6 clocks
// [R5] DLL frozen in precharge power-down selects asynchronous ODT response
// [R6] asynchronous response ignores additive latency
// [R7] async turn-on starts after 2 ns, complete by 8.5 ns
// [R8] async turn-off starts after 2 ns, high impedance by 8.5 ns
// [R9] in power-down ODT stays live but reads and writes are not accepted
// [R10] entry window ends when CKE is first registered low
// [R11] a refresh in progress extends entry window to tRFC after it
// [R12] window lead time is write latency minus one clock
// [R13] inside a window either sync or async timing is acceptable
// [R14] exit window ends tXPDLL after CKE registered high, then sync
// [R15] ODT changes before the entry window get synchronous response
// [R16] overlapping entry then exit windows allow either response throughout
// [R17] overlapping exit then entry windows allow either response throughout
// [R18] sync termination follows registered ODT by write latency minus two
// [R19] dynamic ODT selects write strength after a write, nominal after 4 or 6 more
// [R20] outside power-down and windows ODT is synchronous with additive latency
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`include "dom_params.svh"
`timescale 1ns/10ps
`default_nettype none
module dom_odt_timing #(
    parameter int SR_DEPTH = 32
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ck_pin,
    input wire logic cke_pin,
    input wire logic odt_pin,
    input wire logic wr_pin,
    input wire logic bc4_pin,
    input wire logic ref_pin,
    output logic rtt_on,
    output logic rtt_wr_sel,
    output logic async_active
);
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    dom_pkg::dom_pins_s pin_m;
    dom_pkg::dom_pins_s pin_s;
    logic ck_d;
    dom_pkg::dom_cfg_s cfg;
    logic [7:0] trfc;
    logic [7:0] txp;
    logic odth_err;
    logic ack;
    logic [SR_DEPTH-1:0] odt_sr;
    logic [2:0] hi_cnt;
    logic [2:0] wh_cnt;
    logic [2:0] wh_need;
    logic wh_act;
    logic wr_run;
    logic [5:0] wr_cnt;
    logic [5:0] wr_end;
    logic [7:0] ref_cnt;
    logic [7:0] xp_cnt;
    dom_pkg::dom_st_e st;

    // pins cross from the controller's clock; ck itself is only sampled
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            pin_m <= '0;
            pin_s <= '0;
            ck_d <= 1'b0;
        end
        else
        begin
            pin_m <= {ck_pin, cke_pin, odt_pin, wr_pin, bc4_pin, ref_pin};
            pin_s <= pin_m;
            ck_d <= pin_s.ck;
        end
    end

    wire ck_rise = pin_s.ck & ~ck_d;
    wire [4:0] wl = {1'b0, cfg.al} + {1'b0, cfg.cwl}; // [R20]
    wire [4:0] odtl = (wl > 5'h02) ? wl - 5'h02 : 5'h00;
    wire [4:0] anpd = (wl > 5'h01) ? wl - 5'h01 : 5'h00; // [R12]
    wire in_pd = (st != dom_pkg::DOM_ACT);
    wire wr_evt = ck_rise & pin_s.wr & ~in_pd; // [R9]
    wire ref_evt = ck_rise & pin_s.ref_c & ~in_pd;
    wire ref_busy = (ref_cnt != 8'h00);
    wire odt_rise = ck_rise & pin_s.odt & ~odt_sr[0];
    wire odt_fall = ck_rise & ~pin_s.odt & odt_sr[0];
    wire [2:0] bst_need = pin_s.bc4 ? `DOM_ODTH4 : `DOM_ODTH8;
    // a write with ODT low starts no hold; only the rise count applies then
    wire viol = odt_fall & ((hi_cnt < `DOM_ODTH4) | (wh_act & (wh_cnt < wh_need))); // [R2]
    // async is chosen only once CKE is low and any refresh has run out
    wire async_mode = ~cfg.a12 & in_pd & ~ref_busy; // [R5] [R15]
    wire sync_odt = odt_sr[odtl]; // [R18]
    // async needs one clk: 8 ns sits between the 2 ns and 8.5 ns limits
    wire next_rtt = async_mode ? pin_s.odt : sync_odt; // [R6] [R7] [R8]
    wire next_rtt_wr = wr_run & (wr_cnt >= {1'b0, odtl}) & (wr_cnt < wr_end); // [R19]
    wire bus_req = avs_read | avs_write;
    wire wr_go = avs_write & ack;
    wire [1:0] widx = avs_address[3:2];
    wire [31:0] stat = {11'h000, anpd, 7'h00, odth_err, 2'h0, ref_busy,
                        st == dom_pkg::DOM_EXIT, in_pd, async_active, rtt_wr_sel, rtt_on};
    wire [31:0] rd_mux = (widx == `DOM_CFG_OFS) ? {22'h0, cfg} :
                         (widx == `DOM_TRFC_OFS) ? {24'h000000, trfc} :
                         (widx == `DOM_TXP_OFS) ? {24'h000000, txp} : stat;
    wire [31:0] cfg_m = be_merge({22'h0, cfg}, avs_writedata, avs_byteenable);
    wire [31:0] trfc_m = be_merge({24'h000000, trfc}, avs_writedata, avs_byteenable);
    wire [31:0] txp_m = be_merge({24'h000000, txp}, avs_writedata, avs_byteenable);
    wire err_clr = wr_go & (widx == `DOM_STAT_OFS) & avs_byteenable[1] &
                   avs_writedata[`DOM_ST_ERR];
    wire addr_ok = (avs_address[1:0] == 2'h0);

    assign avs_waitrequest = bus_req & ~ack;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            ack <= 1'b0;
            avs_readdata <= 32'h00000000;
            cfg <= `DOM_CFG_RST;
            trfc <= `DOM_TRFC_RST;
            txp <= `DOM_TXP_RST;
            odth_err <= 1'b0;
        end
        else
        begin
            ack <= bus_req & ~ack;
            avs_readdata <= (avs_read & ~ack) ? (addr_ok ? rd_mux : 32'h00000000) : avs_readdata;
            cfg <= (wr_go & addr_ok & (widx == `DOM_CFG_OFS)) ? cfg_m[`DOM_CFG_W-1:0] : cfg;
            trfc <= (wr_go & addr_ok & (widx == `DOM_TRFC_OFS)) ? trfc_m[7:0] : trfc;
            txp <= (wr_go & addr_ok & (widx == `DOM_TXP_OFS)) ? txp_m[7:0] : txp;
            // a violation in the clearing cycle is kept
            odth_err <= viol | (odth_err & ~(err_clr & addr_ok)); // [R1]
        end
    end

    // history of registered ODT, one step per CK rise
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            odt_sr <= '0;
        end
        else if (ck_rise)
        begin
            odt_sr <= {odt_sr[SR_DEPTH-2:0], pin_s.odt};
        end
    end

    // hold counters saturate at 7, above every needed span
    wire wh_start = wr_evt & pin_s.odt; // [R3]
    wire [2:0] next_hi_cnt = odt_rise ? 3'h1 : hi_cnt + {2'h0, pin_s.odt & (hi_cnt != 3'h7)};
    wire [2:0] next_wh_cnt = wh_start ? 3'h1 : wh_cnt + {2'h0, pin_s.odt & (wh_cnt != 3'h7)};
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            hi_cnt <= 3'h0;
            wh_cnt <= 3'h0;
            wh_need <= 3'h0;
            wh_act <= 1'b0;
        end
        else if (ck_rise)
        begin
            hi_cnt <= next_hi_cnt;
            wh_cnt <= next_wh_cnt;
            wh_need <= wh_start ? bst_need : wh_need; // [R4]
            wh_act <= wh_start | (wh_act & pin_s.odt);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            wr_run <= 1'b0;
            wr_cnt <= 6'h00;
            wr_end <= 6'h00;
        end
        else if (wr_evt)
        begin
            wr_run <= cfg.dyn_en;
            wr_cnt <= 6'h00;
            wr_end <= {1'b0, odtl} + (pin_s.bc4 ? `DOM_CWN4 : `DOM_CWN8); // [R19]
        end
        else if (ck_rise & wr_run)
        begin
            wr_run <= (wr_cnt != wr_end);
            wr_cnt <= wr_cnt + {5'h00, wr_cnt != wr_end};
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            ref_cnt <= 8'h00;
        end
        else if (ref_evt | (ck_rise & ref_busy))
        begin
            ref_cnt <= ref_evt ? trfc : ref_cnt - 8'h01; // [R11]
        end
    end

    // the device cannot see CKE ahead of time, so the entry window stays
    // synchronous until CKE low, and the exit lead stays asynchronous
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st <= dom_pkg::DOM_ACT;
            xp_cnt <= 8'h00;
        end
        else if (ck_rise)
        begin
            unique case (st)
                dom_pkg::DOM_ACT:
                begin
                    if (~pin_s.cke)
                    begin
                        st <= dom_pkg::DOM_PD; // [R10]
                    end
                end
                dom_pkg::DOM_PD:
                begin
                    if (pin_s.cke)
                    begin
                        st <= dom_pkg::DOM_EXIT;
                        xp_cnt <= txp;
                    end
                end
                dom_pkg::DOM_EXIT:
                begin
                    if (~pin_s.cke)
                    begin
                        st <= dom_pkg::DOM_PD; // [R17]
                    end
                    else if (xp_cnt == 8'h00)
                    begin
                        st <= dom_pkg::DOM_ACT; // [R14]
                    end
                    else
                    begin
                        xp_cnt <= xp_cnt - 8'h01;
                    end
                end
            endcase
        end
    end

    // the path mux may glitch once at a mode switch; windows allow it
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            rtt_on <= 1'b0;
            rtt_wr_sel <= 1'b0;
            async_active <= 1'b0;
        end
        else
        begin
            rtt_on <= next_rtt; // [R13]
            rtt_wr_sel <= next_rtt_wr;
            async_active <= async_mode; // [R16]
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence async_hi_s;
        async_mode && pin_s.odt;
    endsequence
    sequence async_lo_s;
        async_mode && !pin_s.odt;
    endsequence
    sequence sync_pend_s;
        !async_mode && sync_odt;
    endsequence

    async_on_a: assert property (async_hi_s |=> rtt_on) // [R7]
        else $error("async turn-on late");
    async_off_a: assert property (async_lo_s |=> !rtt_on) // [R8]
        else $error("async turn-off late");
    async_noal_a: assert property (async_mode && cfg.al != 4'h0 && $changed(pin_s.odt)
        |=> rtt_on == $past(pin_s.odt)) // [R6]
        else $error("async path delayed by additive latency");
    sync_lat_a: assert property (sync_pend_s |=> rtt_on) // [R18]
        else $error("sync turn-on not at write latency minus two");
    entry_sync_a: assert property (st == dom_pkg::DOM_ACT |-> !async_mode) // [R15]
        else $error("async response before power-down");
    pd_async_a: assert property (st == dom_pkg::DOM_PD && !cfg.a12 && !ref_busy
        |-> ##1 async_active) // [R5]
        else $error("frozen power-down not async");
    ref_hold_a: assert property (ref_busy |-> !async_mode) // [R11]
        else $error("async during refresh");
    exit_len_a: assert property (st == dom_pkg::DOM_EXIT |-> xp_cnt <= txp) // [R14]
        else $error("exit window count out of range");
    pd_nowr_a: assert property (in_pd && ck_rise && pin_s.wr && !wr_run
        |=> $stable(wr_end) && !wr_run) // [R9]
        else $error("write accepted in power-down");
    dyn_wr_a: assert property (rtt_wr_sel |-> $past(wr_run)
        && $past(wr_cnt) >= {1'b0, $past(odtl)}) // [R19]
        else $error("write strength outside dynamic span");
    odth_a: assert property (viol |=> odth_err) // [R1]
        else $error("hold violation not flagged");
    odth8_a: assert property (odt_fall && wh_act && wh_need == `DOM_ODTH8
        && wh_cnt < `DOM_ODTH8 |=> odth_err) // [R4]
        else $error("BL8 hold violation not flagged");
endmodule
`default_nettype wire

// file: src/dom_params.svh
`ifndef DOM_PARAMS_SVH
`define DOM_PARAMS_SVH
`define DOM_CFG_OFS 2'h0
`define DOM_TRFC_OFS 2'h1
`define DOM_TXP_OFS 2'h2
`define DOM_STAT_OFS 2'h3
`define DOM_CFG_W 10
`define DOM_CFG_RST 10'h250
`define DOM_TRFC_RST 8'h40
`define DOM_TXP_RST 8'h0a
`define DOM_ST_ERR 8
`define DOM_ST_ANPD 16
`define DOM_ODTH4 3'h4
`define DOM_ODTH8 3'h6
`define DOM_CWN4 6'h04
`define DOM_CWN8 6'h06
`define DOM_CLK_PS 8000
`define DOM_TAONPD_MIN_PS 2000
`define DOM_TAONPD_MAX_PS 8500
`define DOM_TAON_MIN_CYC ((`DOM_TAONPD_MIN_PS + `DOM_CLK_PS - 1) / `DOM_CLK_PS)
`define DOM_TAON_MAX_CYC (`DOM_TAONPD_MAX_PS / `DOM_CLK_PS)
`endif

// file: src/dom_pkg.sv
package dom_pkg;
    typedef struct packed {
        logic dyn_en;
        logic a12;
        logic [3:0] cwl;
        logic [3:0] al;
    } dom_cfg_s;
    typedef struct packed {
        logic ck;
        logic cke;
        logic odt;
        logic wr;
        logic bc4;
        logic ref_c;
    } dom_pins_s;
    typedef enum logic [1:0] {DOM_ACT, DOM_PD, DOM_EXIT} dom_st_e;
endpackage

// file: sim/dom_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module dom_ctrl_model (
    output var logic ck,
    output var logic cke,
    output var logic odt,
    output var logic wr,
    output var logic bc4,
    output var logic ref_c
);
    initial
    begin
        ck = 1'b0;
        {cke, odt, wr, bc4, ref_c} = 5'h10;
    end
    // ck stands low between frames; pins settle well ahead of each rise
    // callers hold odt for the full span save one BL8 burst cut to 4 rises; a write in power-down only probes refusal
    task automatic rise(input logic [4:0] v);
    begin
        #3 {cke, odt, wr, bc4, ref_c} = v;
        #21 ck = 1'b1;
        #56 ck = 1'b0;
    end
    endtask
    // odt receiver stays live in power-down, so odt moves with ck idle
    task automatic set_odt(input logic v);
    begin
        odt = v;
        #40;
    end
    endtask
endmodule
`default_nettype wire

// file: sim/dom_odt_timing_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dom_odt_timing_tb;
    typedef struct packed {logic w; logic [3:0] a; logic [31:0] d;} dom_row_s;
    logic clk;
    logic resetn;
    logic [3:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [3:0] bus_be;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ck, cke, odt, wr, bc4, ref_c;
    logic rtt_on, rtt_wr_sel, async_active;
    logic [31:0] rd;
    int error_cnt = 0;
    int samples_checked = 0;
    dom_row_s rows [13];

    dom_ctrl_model ctrl_u (.ck(ck), .cke(cke), .odt(odt), .wr(wr), .bc4(bc4), .ref_c(ref_c));
    dom_odt_timing dut_u (
        .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ck_pin(ck),
        .cke_pin(cke), .odt_pin(odt), .wr_pin(wr), .bc4_pin(bc4), .ref_pin(ref_c),
        .rtt_on(rtt_on), .rtt_wr_sel(rtt_wr_sel), .async_active(async_active)
    );

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [31:0] w1(input logic x);
        return {31'h0, x};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        samples_checked++;
        if (got !== exp)
        begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    end
    endtask

    task automatic end_sim;
    begin
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask

    // request held until waitrequest is sampled low at a rising edge, released there
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
    begin
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= bus_be;
        avs_write <= w;
        avs_read <= ~w;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
        begin
            n++;
            if (n >= 40)
            begin
                error_cnt++;
                end_sim();
            end
            @(posedge clk);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    end
    endtask

    task automatic rises(input int n, input logic [4:0] v);
    begin
        repeat (n) ctrl_u.rise(v);
    end
    endtask

    // odt high for n rises, optional write at rise 0; lat is write latency minus two
    task automatic burst(input logic w, input logic b4, input int n, input int lat,
                         input logic e);
    begin
        for (int k = 0; k < 12; k++)
        begin
            ctrl_u.rise({1'b1, k < n, w && k == 0, b4, 1'b0});
            chk(w1(rtt_on), w1(k >= lat && k < n + lat));
            chk(w1(rtt_wr_sel), w1(w && k >= lat && k < lat + (b4 ? 4 : 6)));
        end
        bus(1'b0, 4'hc, 32'h0);
        chk(w1(rd[8]), w1(e));
        bus(1'b1, 4'hc, 32'h100);
    end
    endtask

    initial
    begin
        #100000;
        error_cnt++;
        end_sim();
    end

    initial
    begin
        resetn = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        bus_be = 4'hf;
        rows = '{'{0, 4'h0, 32'h250}, '{0, 4'h4, 32'h40}, '{0, 4'h8, 32'h0a},
                 '{0, 4'hc, 32'h40000}, '{0, 4'h1, 32'h0}, '{1, 4'h1, 32'hff},
                 '{0, 4'h0, 32'h250}, '{1, 4'h4, 32'h08}, '{0, 4'h4, 32'h08},
                 '{1, 4'h8, 32'h03}, '{0, 4'h8, 32'h03}, '{1, 4'hc, 32'hffff},
                 '{0, 4'hc, 32'h40000}};
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        foreach (rows[i])
        begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w)
                chk(rd, rows[i].d);
        end
        burst(1'b1, 1'b1, 4, 3, 1'b0);
        burst(1'b1, 1'b0, 6, 3, 1'b0);
        burst(1'b0, 1'b0, 4, 3, 1'b0);
        burst(1'b1, 1'b0, 4, 3, 1'b1);
        bus(1'b1, 4'h0, 32'h252);
        burst(1'b0, 1'b0, 5, 5, 1'b0);
        // frozen then running dll; additive latency 2 must not delay async path
        for (int m = 0; m < 2; m++)
        begin
            bus(1'b1, 4'h0, m ? 32'h352 : 32'h252);
            rises(1, 5'h00);
            rises(2, 5'h04);
            chk(w1(async_active), w1(m == 0));
            ctrl_u.set_odt(1'b1);
            chk(w1(rtt_on), w1(m == 0));
            ctrl_u.set_odt(1'b0);
            chk(w1(rtt_on), 32'h0);
            ctrl_u.rise(5'h10);
            chk(w1(async_active), w1(m == 0));
            rises(6, 5'h10);
            chk(w1(async_active), 32'h0);
            chk(w1(rtt_wr_sel), 32'h0);
        end
        bus(1'b1, 4'h0, 32'h252);
        ctrl_u.rise(5'h11);
        rises(3, 5'h00);
        chk(w1(async_active), 32'h0);
        rises(8, 5'h00);
        chk(w1(async_active), 32'h1);
        ctrl_u.set_odt(1'b1);
        chk(w1(rtt_on), 32'h1);
        // reset in mid power-down must drop every output
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        chk({29'h0, rtt_on, rtt_wr_sel, async_active}, 32'h0);
        ctrl_u.set_odt(1'b0);
        rises(2, 5'h10);
        bus(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h250);
        bus_be = 4'h1;
        bus(1'b1, 4'h0, 32'h353);
        bus_be = 4'hf;
        bus(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h253);
        end_sim();
    end
endmodule
`default_nettype wire
